/* acs_pkg.sv */
/*
  Constants shared by the converter channel sequencer: bus offsets,
  control word layout, reset values and the frame timing.
  Assumes nothing of its surroundings; it holds definitions only.
*/
`default_nettype none

package acs_pkg;

    // Byte offsets of the bus registers
    localparam logic [3:0] REG_SAMPLE_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_FRAMES_OFS = 4'h8;

    // Serial word: 16 bits, control word in the upper twelve
    localparam int FRAME_BITS = 16;
    localparam int CTRL_W = 12;
    localparam int CODE_W = 12;
    localparam int WORD_CTRL_LSB = 4;

    // Control word field positions
    localparam int CTRL_WRITE_BIT = 11;
    localparam int CTRL_SEQUENCE_BIT = 10;
    localparam int CTRL_ADDR_LSB = 6;
    localparam int CTRL_SHADOW_BIT = 3;
    localparam int CTRL_RANGE_BIT = 0;

    // Falling edge index (from 0) that returns the track-and-hold to track
    localparam logic [3:0] TRACK_EDGE_IDX = 4'hd;
    localparam logic [3:0] LAST_EDGE_IDX = 4'hf;

    // Reset values
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [15:0] SHADOW_RST = 16'h0000;
    localparam logic [11:0] SAMPLE_RST = 12'h000;
    localparam logic [3:0] CHANNEL_RST = 4'h0;

    // Channel selection modes
    typedef enum logic [1:0] {
        ACS_MODE_SINGLE = 2'b00,
        ACS_MODE_SHADOW = 2'b01,
        ACS_MODE_CONSEC = 2'b10
    } acs_mode_e;

endpackage : acs_pkg

`default_nettype wire

/* acs_sequencer.sv */
/*
  Channel sequencer and serial port of a 16-input 12-bit converter,
  with an Avalon-MM slave for a sample stand-in and status readback.
  Assumes a host that frames each transfer with exactly sixteen
  falling serial clock edges while the frame select is low.
*/
// What this block does
// - Range bit, control LSB, picks straight binary or twos complement coding.
// - Same range bit sets input span to one or two references.
// - Outside sequencing, convert the one channel in the address bits.
// - Sequence 1 with shadow 0 cycles shadow-flagged channels ascending, but leaves a running consecutive sequence going.
// - After shadow programming, next transfer converts the lowest selected channel.
// - Each following transfer moves to the next higher selected channel.
// - Sequence runs until a write carries a pair other than 1,0.
// - After the last selected channel, wrap to the first one.
// - Sequence and shadow 1,1 step channel 0 up to the address bits.
// - After the last consecutive channel restart at 0 unless rewritten.
// - Each output word is channel address then 12-bit result.
// - Step to the next channel on the sixteenth falling serial clock edge of each frame.
// - Serial clock shifts data both ways and clocks the conversion.
// - Track-and-hold returns to track on the fourteenth falling edge.
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer #(
    parameter int AVS_ADDR_W = 4
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic CONV_SERIAL_CLOCK_I,
    input wire logic CONV_FRAME_SELECT_N_I,
    input wire logic CONV_SERIAL_IN_I,
    output logic CONV_SERIAL_OUT_O,
    output logic [3:0] MUX_CHANNEL_O,
    output logic RANGE_DOUBLE_O,
    output logic TRACK_MODE_O,
    input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O
);

    // State of the system clock side
    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        logic [11:0] sample;
        logic send;
        logic ack_m;
        logic ack_s;
        logic st_m;
        logic st_s;
        logic st_seen;
        logic [15:0] status;
        logic [15:0] frames;
    } acs_sys_s;

    // State of the serial clock side
    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic samp_m;
        logic samp_s;
        logic ack;
        logic [11:0] sample;
        logic [3:0] cnt;
        logic [14:0] shin;
        logic [15:0] sout;
        logic dout;
        logic [11:0] ctrl;
        logic [15:0] shadow;
        acs_pkg::acs_mode_e mode;
        logic [3:0] cur;
        logic [3:0] last;
        logic [3:0] conv_ch;
        logic shd_pend;
        logic track;
        logic [15:0] status;
        logic st_tgl;
    } acs_link_s;

    acs_sys_s s_q, s_d;
    acs_link_s l_q, l_d;

    // Next flagged channel above cur, wrapping; cur itself if none flagged
    function automatic logic [3:0] next_sel(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] idx;
        logic found;
        begin
            next_sel = cur;
            found = 1'b0;
            for (int k = 1; k <= 16; k++) begin
                idx = cur + 4'(k); // Four-bit sum wraps past channel 15
                if (!found && mask[idx]) begin
                    next_sel = idx;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // Channel number held in a control word, plain unsigned binary
    function automatic logic [3:0] ctrl_addr(input logic [11:0] ctrl);
        ctrl_addr = ctrl[acs_pkg::CTRL_ADDR_LSB +: 4];
    endfunction

    // Register read decode; unmapped offsets read as zero
    function automatic logic [31:0] reg_read(input logic [3:0] ofs, input acs_sys_s s);
        case (ofs)
            acs_pkg::REG_SAMPLE_OFS: reg_read = {20'h00000, s.sample};
            acs_pkg::REG_STATUS_OFS: reg_read = {16'h0000, s.status};
            acs_pkg::REG_FRAMES_OFS: reg_read = {16'h0000, s.frames};
            default: reg_read = 32'h00000000;
        endcase
    endfunction

    logic [3:0] bus_ofs;
    logic sample_busy;

    assign bus_ofs = 4'(AVS_ADDRESS_I);
    // A new sample waits until the serial side has taken the last one
    assign sample_busy = s_q.send != s_q.ack_s;

    // System side: bus slave and status capture from the serial side
    always_comb begin
        s_d = s_q;
        s_d.ack_m = l_q.ack;
        s_d.ack_s = s_q.ack_m;
        s_d.st_m = l_q.st_tgl;
        s_d.st_s = s_q.st_m;
        // Status word is stable for a whole frame, far longer than the sync delay
        if (s_q.st_s != s_q.st_seen) begin
            s_d.st_seen = s_q.st_s;
            s_d.status = l_q.status;
            s_d.frames = s_q.frames + 16'h0001;
        end
        s_d.wait_req = 1'b1;
        if ((AVS_READ_I || AVS_WRITE_I) && s_q.wait_req) begin
            if (!(AVS_WRITE_I && bus_ofs == acs_pkg::REG_SAMPLE_OFS && sample_busy)) begin
                s_d.wait_req = 1'b0;
                s_d.rdata = AVS_READ_I ? reg_read(bus_ofs, s_q) : 32'h00000000;
                if (AVS_WRITE_I && bus_ofs == acs_pkg::REG_SAMPLE_OFS) begin
                    if (AVS_BYTEENABLE_I[0]) begin
                        s_d.sample[7:0] = AVS_WRITEDATA_I[7:0];
                    end
                    if (AVS_BYTEENABLE_I[1]) begin
                        s_d.sample[11:8] = AVS_WRITEDATA_I[11:8];
                    end
                    s_d.send = ~s_q.send;
                end
            end
        end
        if (RESET_I) begin
            s_d = '0;
            s_d.wait_req = 1'b1;
            s_d.sample = acs_pkg::SAMPLE_RST;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        s_q <= s_d;
    end

    logic [15:0] in_word;
    logic [11:0] coded;
    logic [15:0] out_word;
    logic [11:0] nctrl;
    logic [1:0] pair;

    // Serial side: one step per falling edge of the serial clock
    always_comb begin
        l_d = l_q;
        in_word = {l_q.shin, CONV_SERIAL_IN_I};
        nctrl = in_word[acs_pkg::WORD_CTRL_LSB +: acs_pkg::CTRL_W];
        pair = {nctrl[acs_pkg::CTRL_SEQUENCE_BIT], nctrl[acs_pkg::CTRL_SHADOW_BIT]};
        // Twos complement is straight binary with the top bit turned round
        coded = l_q.ctrl[acs_pkg::CTRL_RANGE_BIT] ?
            {~l_q.sample[11], l_q.sample[10:0]} : l_q.sample;
        out_word = {l_q.cur, coded};
        l_d.rst_m = RESET_I;
        l_d.rst_s = l_q.rst_m;
        l_d.samp_m = s_q.send;
        l_d.samp_s = l_q.samp_m;
        // The sample holds still until the acknowledge toggle gets back
        if (l_q.samp_s != l_q.ack) begin
            l_d.sample = s_q.sample;
            l_d.ack = l_q.samp_s;
        end
        if (CONV_FRAME_SELECT_N_I) begin
            // Frame select high at an edge aborts any partial frame
            l_d.cnt = 4'h0;
            l_d.dout = 1'b0;
        end else begin
            l_d.cnt = l_q.cnt + 4'h1;
            l_d.shin = in_word[14:0];
            if (l_q.cnt == 4'h0) begin
                // First edge after frame select falls: hold and convert cur
                l_d.dout = out_word[15];
                l_d.sout = {out_word[14:0], 1'b0};
                l_d.track = 1'b0;
                l_d.conv_ch = l_q.cur;
            end else begin
                l_d.dout = l_q.sout[15];
                l_d.sout = {l_q.sout[14:0], 1'b0};
            end
            if (l_q.cnt == acs_pkg::TRACK_EDGE_IDX) begin
                l_d.track = 1'b1;
            end
            if (l_q.cnt == acs_pkg::LAST_EDGE_IDX) begin
                // Default advance when the frame leaves the setup alone
                case (l_q.mode)
                    acs_pkg::ACS_MODE_SHADOW: l_d.cur = next_sel(l_q.shadow, l_q.cur);
                    acs_pkg::ACS_MODE_CONSEC: l_d.cur = (l_q.cur == l_q.last) ? 4'h0 : l_q.cur + 4'h1;
                    default: l_d.cur = ctrl_addr(l_q.ctrl);
                endcase
                if (l_q.shd_pend) begin
                    // This frame carried the channel mask, not a control word
                    l_d.shadow = in_word;
                    l_d.shd_pend = 1'b0;
                    l_d.mode = acs_pkg::ACS_MODE_SHADOW;
                    l_d.cur = next_sel(in_word, 4'hf);
                end else if (nctrl[acs_pkg::CTRL_WRITE_BIT]) begin
                    l_d.ctrl = nctrl;
                    case (pair)
                        2'b10: begin
                            // A running sequence carries on untouched
                            if (l_q.mode == acs_pkg::ACS_MODE_SINGLE) begin
                                l_d.mode = acs_pkg::ACS_MODE_SHADOW;
                                l_d.cur = next_sel(l_q.shadow, 4'hf);
                            end
                        end
                        2'b11: begin
                            l_d.mode = acs_pkg::ACS_MODE_CONSEC;
                            l_d.last = ctrl_addr(nctrl);
                            l_d.cur = 4'h0;
                        end
                        2'b01: begin
                            l_d.mode = acs_pkg::ACS_MODE_SINGLE;
                            l_d.shd_pend = 1'b1;
                            l_d.cur = ctrl_addr(nctrl);
                        end
                        default: begin
                            l_d.mode = acs_pkg::ACS_MODE_SINGLE;
                            l_d.cur = ctrl_addr(nctrl);
                        end
                    endcase
                end
                l_d.status = {4'h0, l_d.shd_pend, l_d.ctrl[acs_pkg::CTRL_RANGE_BIT],
                    l_d.mode, l_d.cur, l_q.conv_ch};
                l_d.st_tgl = ~l_q.st_tgl;
            end
        end
        if (l_q.rst_s) begin
            l_d = '0;
            // Keep sampling the pin, else the sync would never let go
            l_d.rst_m = RESET_I;
            l_d.rst_s = l_q.rst_m;
            l_d.ctrl = acs_pkg::CTRL_RST;
            l_d.shadow = acs_pkg::SHADOW_RST;
            l_d.sample = acs_pkg::SAMPLE_RST;
            l_d.cur = acs_pkg::CHANNEL_RST;
            l_d.mode = acs_pkg::ACS_MODE_SINGLE;
            l_d.track = 1'b1;
        end
    end

    // Device acts on falling serial clock edges only
    always_ff @(negedge CONV_SERIAL_CLOCK_I) begin
        l_q <= l_d;
    end

    // Outputs straight from the state flops
    assign CONV_SERIAL_OUT_O = l_q.dout;
    assign MUX_CHANNEL_O = l_q.cur;
    assign RANGE_DOUBLE_O = l_q.ctrl[acs_pkg::CTRL_RANGE_BIT];
    assign TRACK_MODE_O = l_q.track;
    assign AVS_READDATA_O = s_q.rdata;
    assign AVS_WAITREQUEST_O = s_q.wait_req;

endmodule // acs_sequencer

`default_nettype wire

/* acs_properties.sv */
/* Port checker for the converter channel sequencer.
   Assumes a bind to acs_sequencer and a host that frames sixteen falling serial edges. */
`timescale 1ns/1ps
`default_nettype none
module acs_properties (
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    input wire logic CONV_SERIAL_CLOCK_I,
    input wire logic CONV_FRAME_SELECT_N_I,
    input wire logic CONV_SERIAL_OUT_O,
    input wire logic [3:0] MUX_CHANNEL_O,
    input wire logic RANGE_DOUBLE_O,
    input wire logic TRACK_MODE_O,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O
);
    logic [3:0] edge_q;
    logic first_w;
    // Edge index in a frame; wraps after sixteen so back to back frames stay aligned
    always_ff @(negedge CONV_SERIAL_CLOCK_I) begin
        edge_q <= (RESET_I || CONV_FRAME_SELECT_N_I) ? 4'h0 : edge_q + 4'h1;
    end
    assign first_w = !CONV_FRAME_SELECT_N_I && edge_q == 4'h0;
    // Channel tag leads the word, MSB first, taken from the channel at frame start
    sequence s_tag;
        CONV_SERIAL_OUT_O == $past(MUX_CHANNEL_O[3]) ##1 CONV_SERIAL_OUT_O == $past(MUX_CHANNEL_O[2], 2)
        ##1 CONV_SERIAL_OUT_O == $past(MUX_CHANNEL_O[1], 3) ##1 CONV_SERIAL_OUT_O == $past(MUX_CHANNEL_O[0], 4);
    endsequence
    a_tag_leads_word: assert property (
        @(negedge CONV_SERIAL_CLOCK_I) disable iff (RESET_I) first_w |=> s_tag) else $error("channel tag wrong");
    a_hold_at_start: assert property (
        @(negedge CONV_SERIAL_CLOCK_I) disable iff (RESET_I) first_w |=> !TRACK_MODE_O [*8])
        else $error("hold not kept early in frame");
    a_track_at_14: assert property (
        @(negedge CONV_SERIAL_CLOCK_I) disable iff (RESET_I)
        !CONV_FRAME_SELECT_N_I && edge_q == 4'hd |=> TRACK_MODE_O) else $error("track not back on edge 14");
    a_mux_frame_end: assert property (
        @(negedge CONV_SERIAL_CLOCK_I) disable iff (RESET_I)
        CONV_FRAME_SELECT_N_I || edge_q != 4'hf |=> $stable(MUX_CHANNEL_O)) else $error("channel moved mid frame");
    a_range_frame_end: assert property (
        @(negedge CONV_SERIAL_CLOCK_I) disable iff (RESET_I)
        CONV_FRAME_SELECT_N_I || edge_q != 4'hf |=> $stable(RANGE_DOUBLE_O)) else $error("range moved mid frame");
    // Bus side: one low cycle of waitrequest per request, data held while no request is made
    a_wait_one_low: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("waitrequest low too long");
    a_wait_needs_req: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        $fell(AVS_WAITREQUEST_O) |-> $past(AVS_READ_I || AVS_WRITE_I)) else $error("answer without request");
    a_read_data_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        !AVS_READ_I && !AVS_WRITE_I |=> $stable(AVS_READDATA_O)) else $error("read data changed without read");
    // A write answer carries zero data, so read data only stands between reads and writes
    a_write_reads_zero: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
        $past(AVS_WRITE_I) && !AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0) else $error("write answer data not zero");
    a_reset_idle: assert property (@(posedge CLK_SYS_I)
        RESET_I |=> AVS_WAITREQUEST_O && AVS_READDATA_O == 32'h0) else $error("bus not idle in reset");
endmodule // acs_properties
`default_nettype wire

/* acs_host_model.sv */
/* Host serial master model: frames of sixteen falling edges on a 30 ns clock.
   Assumes the bench calls tick around reset and xfer once per frame. */
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    output logic SCLK_O,
    output logic FS_N_O,
    output logic SDI_O,
    input wire logic SDO_I
);
    // Clock idles high and stands still between frames
    initial begin
        SCLK_O = 1'b1;
        FS_N_O = 1'b1;
        SDI_O = 1'b0;
    end
    // Free clocks with frame select high; the device needs them to sync its reset
    task automatic tick(input int n);
        repeat (n) begin
            #15 SCLK_O = 1'b0;
            #15 SCLK_O = 1'b1;
        end
    endtask
    // Data changes after each rising edge; released line shows the inverse of its last bit
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        SDI_O = w[15];
        FS_N_O = 1'b0;
        for (int k = 15; k >= 0; k--) begin
            tick(1);
            r[k] = SDO_I;
            SDI_O = (k > 0) ? w[k-1] : ~w[0];
        end
        #15 FS_N_O = 1'b1;
    endtask
endmodule // acs_host_model
`default_nettype wire

/* tb.sv */
/* Self-checking bench for acs_sequencer with a host serial model.
   Assumes acs_pkg, acs_properties and acs_host_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
bind acs_sequencer acs_properties u_props (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
    .CONV_SERIAL_CLOCK_I(CONV_SERIAL_CLOCK_I), .CONV_FRAME_SELECT_N_I(CONV_FRAME_SELECT_N_I),
    .CONV_SERIAL_OUT_O(CONV_SERIAL_OUT_O), .MUX_CHANNEL_O(MUX_CHANNEL_O), .RANGE_DOUBLE_O(RANGE_DOUBLE_O),
    .TRACK_MODE_O(TRACK_MODE_O), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O));
module tb;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, fresh, rng, pend, sclk, fsn, sdi, sdo, wreq, rng_o, trk;
    logic [3:0] adr = 4'h0, mux, ch, prev, last;
    logic [31:0] wd = 32'h0, rdd, rdat, r, seed = 32'hfb48db3e;
    logic [11:0] smp;
    logic [15:0] mask, rx;
    logic [1:0] mode;
    int bad_count = 0, n_compared = 0, cyc = 0, nfr = 0;
    always #20 clk = ~clk;
    acs_sequencer dut (.CLK_SYS_I(clk), .RESET_I(rst), .CONV_SERIAL_CLOCK_I(sclk), .CONV_FRAME_SELECT_N_I(fsn),
        .CONV_SERIAL_IN_I(sdi), .CONV_SERIAL_OUT_O(sdo), .MUX_CHANNEL_O(mux), .RANGE_DOUBLE_O(rng_o),
        .TRACK_MODE_O(trk), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdd), .AVS_WAITREQUEST_O(wreq));
    acs_host_model host (.SCLK_O(sclk), .FS_N_O(fsn), .SDI_O(sdi), .SDO_I(sdo));
    // Verdict and the single end of the run
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard: a run of 80 frames needs far fewer cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (exp !== got) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Next flagged channel above c, wrapping; an empty mask leaves the channel alone
    function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] c);
        logic [3:0] k;
        k = c;
        repeat (16) begin
            k = k + 4'h1;
            if (m[k]) return k;
        end
        return c;
    endfunction
    function automatic logic [15:0] cw(input logic s, input logic h, input logic [3:0] a, input logic g);
        return {1'b1, s, a, 2'b00, h, 2'b00, g, 4'h0};
    endfunction
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wr <= we;
        rd <= !we;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdd;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // One frame, checked word, then the model steps as the control word says
    task automatic frame(input logic [15:0] w);
        prev = ch;
        host.xfer(w, rx);
        nfr++;
        if (fresh) chk("tag", ch, rx[15:12]);
        else chk("word", {ch, rng ? smp ^ 12'h800 : smp}, rx);
        fresh = 1'b0;
        if (pend) begin
            pend = 1'b0;
            mask = w;
            mode = 2'h1;
            ch = nxt(w, 4'hf);
        end else if (w[15]) begin
            rng = w[4];
            case ({w[14], w[7]})
                2'b00: ch = w[13:10];
                2'b01: begin ch = w[13:10]; pend = 1'b1; end
                2'b11: begin last = w[13:10]; ch = 4'h0; end
                default: ch = (mode == 2'h2) ? ((ch == last) ? 4'h0 : ch + 4'h1) : nxt(mask, mode == 2'h1 ? ch : 4'hf);
            endcase
            // A 1,0 write leaves a running consecutive sequence going
            mode = w[14] ? (w[7] ? 2'h2 : (mode == 2'h2 ? 2'h2 : 2'h1)) : 2'h0;
        end else if (mode == 2'h1) ch = nxt(mask, ch);
        else if (mode == 2'h2) ch = (ch == last) ? 4'h0 : ch + 4'h1;
        repeat (8) @(posedge clk);
        chk("pins", {rng, ch}, {rng_o, mux});
        bus(1'b0, acs_pkg::REG_STATUS_OFS, 32'h0, rdat);
        chk("status", {20'h0, pend, rng, mode, ch, prev}, rdat);
    endtask
    initial begin
        {ch, last, mode, rng, pend, mask} = '0;
        fork
            host.tick(40);
            begin repeat (20) @(posedge clk); rst <= 1'b0; end
        join
        for (int it = 0; it < 2; it++) begin
            r = rnd();
            smp = r[11:0];
            bus(1'b1, acs_pkg::REG_SAMPLE_OFS, {20'h0, smp}, rdat);
            fresh = 1'b1;
            repeat (3) begin
                r = rnd();
                frame(cw(1'b0, 1'b0, r[3:0], r[4]));
                frame(16'h0000);
            end
            frame(cw(1'b0, 1'b1, r[7:4], rng));
            frame(it == 0 ? 16'h8001 : (r[15:0] & r[31:16]) | 16'h0040);
            repeat (8) frame(16'h0000);
            frame(cw(1'b1, 1'b0, r[11:8], rng));
            repeat (2) frame(16'h0000);
            frame(cw(1'b1, 1'b1, it == 0 ? 4'h0 : 4'hf, r[5]));
            repeat (17) frame(16'h0000);
            frame(cw(1'b1, 1'b0, r[3:0], r[5]));
            repeat (2) frame(16'h0000);
        end
        bus(1'b0, acs_pkg::REG_SAMPLE_OFS, 32'h0, rdat);
        chk("sample", {20'h0, smp}, rdat);
        bus(1'b1, 4'hc, 32'hffffffff, rdat);
        bus(1'b0, 4'hc, 32'h0, rdat);
        chk("unmapped", 32'h0, rdat);
        bus(1'b0, acs_pkg::REG_FRAMES_OFS, 32'h0, rdat);
        chk("frames", nfr, rdat);
        results();
    end
endmodule // tb
`default_nettype wire
